// ---- lpcg_proc_end.sv ----
// processor end: supervisor entry, halt, bus release, wake
`timescale 1ns/10ps
`include "lpcg_consts.svh"
module lpcg_proc_end (
    input  wire logic        clk,          // system clock
    input  wire logic        reset_n,      // async reset, low active
    lpcg_link_if.proc        lnk,          // link to gating logic
    input  wire logic        sw_trap,      // software exception request
    input  wire logic        sw_write_lp,  // write to low-power address
    input  wire logic [23:0] lp_addr,      // chosen low-power address
    input  wire logic [2:0]  wake_level,   // programmed wake level
    input  wire logic [2:0]  irq_level,    // pending interrupt level
    input  wire logic        mode_8bit,    // static width select
    output logic             supervisor,   // supervisor mode flag
    output logic             asleep,       // low-power state flag
    output logic             bus_floated   // outputs released
);
    lpcg_pkg::lpcg_proc_e st_q, st_d;
    logic       rst1_q, rst2_q;
    logic [1:0] cyc_q;
    logic       wake_seen_q;
    wire        run = lnk.clk_en;
    wire        last_fetch = (cyc_q == (mode_8bit ? 2'h3 : 2'h2));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst1_q <= 1'b0;
            rst2_q <= 1'b0;
        end else begin
            rst1_q <= lnk.restart;
            rst2_q <= rst1_q;
        end
    end
    always_comb begin
        st_d = st_q;
        case (st_q)
            lpcg_pkg::LPCG_P_USER:     if (sw_trap) st_d = lpcg_pkg::LPCG_P_SUPER;
            lpcg_pkg::LPCG_P_SUPER:    if (sw_write_lp) st_d = lpcg_pkg::LPCG_P_STOPPING;
            lpcg_pkg::LPCG_P_STOPPING: if (!run) st_d = lpcg_pkg::LPCG_P_ASLEEP;
            lpcg_pkg::LPCG_P_ASLEEP:   if (rst2_q && run && wake_seen_q)
                                           st_d = lpcg_pkg::LPCG_P_RELEASE;
            lpcg_pkg::LPCG_P_RELEASE:  if (!lnk.bus_request_in) st_d = lpcg_pkg::LPCG_P_SUPER;
            default:                   st_d = lpcg_pkg::LPCG_P_USER;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q                      <= lpcg_pkg::LPCG_P_USER;
            cyc_q                     <= 2'h0;
            wake_seen_q               <= 1'b0;
            lnk.address_outputs       <= 24'h000000;
            lnk.rw                    <= 1'b1;
            lnk.function_code_outputs <= 3'h0;
            lnk.bus_cycle_end         <= 1'b0;
            lnk.bus_grant             <= 1'b0;
            lnk.buffered_irq_level_lines <= 3'h0;
            supervisor                <= 1'b0;
            asleep                    <= 1'b0;
            bus_floated               <= 1'b0;
        end else begin
            st_q <= st_d;
            lnk.buffered_irq_level_lines <= irq_level;
            if (st_q == lpcg_pkg::LPCG_P_ASLEEP && irq_level == wake_level)
                wake_seen_q <= 1'b1;
            else if (st_q != lpcg_pkg::LPCG_P_ASLEEP)
                wake_seen_q <= 1'b0;
            supervisor  <= (st_d != lpcg_pkg::LPCG_P_USER);
            asleep      <= (st_d == lpcg_pkg::LPCG_P_ASLEEP);
            lnk.bus_cycle_end <= 1'b0;
            if (run) begin
                if (st_q == lpcg_pkg::LPCG_P_SUPER && sw_write_lp) begin
                    lnk.address_outputs       <= lp_addr;
                    lnk.rw                    <= 1'b0;
                    lnk.function_code_outputs <= `LPCG_FC_SUPER_DATA;
                    lnk.bus_cycle_end         <= 1'b1;
                    cyc_q                     <= 2'h0;
                end else if (st_q == lpcg_pkg::LPCG_P_STOPPING && !last_fetch) begin
                    lnk.rw                    <= 1'b1;
                    lnk.function_code_outputs <= 3'h6;
                    lnk.bus_cycle_end         <= 1'b1;
                    cyc_q                     <= cyc_q + 2'h1;
                end
            end
            if (lnk.bus_request_in && st_q == lpcg_pkg::LPCG_P_STOPPING) begin
                lnk.bus_grant <= 1'b1;
                bus_floated   <= 1'b1;
            end else if (!lnk.bus_request_in) begin
                lnk.bus_grant <= 1'b0;
                bus_floated   <= 1'b0;
            end
        end
    end
endmodule

// ---- lpcg_consts.svh ----
// constants for the low-power clock gating sequencer
`ifndef LPCG_CONSTS_SVH
`define LPCG_CONSTS_SVH
`define LPCG_ADDR_W        24
`define LPCG_FC_SUPER_DATA 3'h5
`define LPCG_CYC_16        3'h3
`define LPCG_CYC_8         3'h4
`define LPCG_CNT_W         3
`define LPCG_STABLE_CYC    8'h10
`endif

// ---- lpcg_pkg.sv ----
// types for the low-power clock gating sequencer
package lpcg_pkg;
    typedef enum logic [1:0] {LPCG_RUN, LPCG_COUNT, LPCG_HALTED, LPCG_WAKE} lpcg_gate_e;
    typedef enum logic [2:0] {LPCG_P_USER, LPCG_P_SUPER, LPCG_P_STOPPING, LPCG_P_ASLEEP,
                              LPCG_P_RELEASE} lpcg_proc_e;
endpackage

// ---- lpcg_link_if.sv ----
// link between the processor end and the clock gating end
`timescale 1ns/10ps
interface lpcg_link_if;
    logic [23:0] address_outputs;
    logic        rw;
    logic [2:0]  function_code_outputs;
    logic        bus_cycle_end;
    logic        clk_en;
    logic [2:0]  buffered_irq_level_lines;
    logic        restart;
    logic        bus_request_in;
    logic        bus_grant;
    logic        bus_8bit;
    modport proc (output address_outputs, rw, function_code_outputs, bus_cycle_end,
                  buffered_irq_level_lines, bus_grant,
                  input clk_en, restart, bus_request_in, bus_8bit);
    modport gate (input address_outputs, rw, function_code_outputs, bus_cycle_end,
                  buffered_irq_level_lines, bus_grant,
                  output clk_en, restart, bus_request_in, bus_8bit);
endinterface

// ---- lpcg_gate_end.sv ----
// gating end: address hit, cycle count, clock stop and restart
`timescale 1ns/10ps
`include "lpcg_consts.svh"
module lpcg_gate_end (
    input  wire logic        clk,          // system clock
    input  wire logic        reset_n,      // async reset, low active
    lpcg_link_if.gate        lnk,          // link to processor
    input  wire logic [23:0] lp_addr,      // chosen low-power address
    input  wire logic [2:0]  wake_level,   // wake interrupt level
    input  wire logic        mode_8bit,    // static width select
    input  wire logic        float_bus,    // float outputs in sleep
    output logic             addr_hit,     // low-power address hit
    output logic             clk_stopped   // processor clock gated off
);
    lpcg_pkg::lpcg_gate_e st_q, st_d;
    logic [`LPCG_CNT_W-1:0] cnt_q;
    logic [7:0] stab_q;
    logic       rs1_q, rs2_q;
    logic       restart_q, en_q;
    wire hit = (lnk.address_outputs == lp_addr) && !lnk.rw
             && (lnk.function_code_outputs == `LPCG_FC_SUPER_DATA)
             && lnk.bus_cycle_end;
    wire [`LPCG_CNT_W-1:0] limit = mode_8bit ? `LPCG_CYC_8 : `LPCG_CYC_16;
    wire wake = (lnk.buffered_irq_level_lines == wake_level);
    always_comb begin
        st_d = st_q;
        case (st_q)
            lpcg_pkg::LPCG_RUN:    if (hit) st_d = lpcg_pkg::LPCG_COUNT;
            lpcg_pkg::LPCG_COUNT:  if (cnt_q >= limit) st_d = lpcg_pkg::LPCG_HALTED;
            lpcg_pkg::LPCG_HALTED: if (wake) st_d = lpcg_pkg::LPCG_WAKE;
            lpcg_pkg::LPCG_WAKE:   if (rs2_q) st_d = lpcg_pkg::LPCG_RUN;
            default:               st_d = lpcg_pkg::LPCG_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q      <= lpcg_pkg::LPCG_RUN;
            cnt_q     <= '0;
            stab_q    <= 8'h00;
            restart_q <= 1'b0;
            rs1_q     <= 1'b0;
            rs2_q     <= 1'b0;
            addr_hit  <= 1'b0;
            lnk.bus_request_in <= 1'b0;
            lnk.bus_8bit       <= 1'b0;
        end else begin
            st_q     <= st_d;
            addr_hit <= hit;
            lnk.bus_8bit <= mode_8bit;
            rs1_q    <= restart_q;
            rs2_q    <= rs1_q;
            // the low-power write itself is bus cycle one
            if (st_q == lpcg_pkg::LPCG_RUN)
                cnt_q <= {{(`LPCG_CNT_W-1){1'b0}}, hit};
            else if (st_q == lpcg_pkg::LPCG_COUNT && lnk.bus_cycle_end)
                cnt_q <= cnt_q + 1'b1;
            if (st_q == lpcg_pkg::LPCG_WAKE && stab_q < `LPCG_STABLE_CYC)
                stab_q <= stab_q + 8'h01;
            else if (st_q != lpcg_pkg::LPCG_WAKE)
                stab_q <= 8'h00;
            restart_q <= (st_q == lpcg_pkg::LPCG_WAKE) && (stab_q >= `LPCG_STABLE_CYC);
            if (st_q == lpcg_pkg::LPCG_COUNT && float_bus)
                lnk.bus_request_in <= 1'b1;
            else if (st_q == lpcg_pkg::LPCG_WAKE && rs2_q)
                lnk.bus_request_in <= 1'b0;
        end
    end
    // enable retimed on the falling edge so the gated clock has full phases
    always_ff @(negedge clk or negedge reset_n) begin
        if (!reset_n)
            en_q <= 1'b1;
        else if (st_q == lpcg_pkg::LPCG_HALTED)
            en_q <= 1'b0;
        else if (st_q == lpcg_pkg::LPCG_RUN || rs2_q)
            en_q <= 1'b1;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lnk.clk_en  <= 1'b1;
            lnk.restart <= 1'b0;
            clk_stopped <= 1'b0;
        end else begin
            lnk.clk_en  <= en_q;
            lnk.restart <= restart_q;
            clk_stopped <= !en_q;
        end
    end
endmodule

// ---- lpcg_asserts.sv ----
// interface checks for the low-power clock gating link
`timescale 1ns/10ps
module lpcg_asserts (
    input wire logic        clk,                      // system clock
    input wire logic        reset_n,                  // async reset, low active
    input wire logic        rw,                       // 1=read
    input wire logic [2:0]  function_code_outputs,    // bus function code
    input wire logic        bus_cycle_end,            // bus cycle pulse
    input wire logic        clk_en,                   // processor clock enable
    input wire logic        restart,                  // clock resume request
    input wire logic        bus_request_in,           // bus request
    input wire logic        bus_grant,                // bus grant
    input wire logic        bus_8bit                  // width select
);
    logic       wr_seen_q;
    logic [3:0] cyc_q;
    wire        sv_wr = bus_cycle_end && !rw && function_code_outputs == 3'h5;
    // fetch cycles counted after a supervisor data write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_seen_q <= 1'b0;
            cyc_q     <= 4'h0;
        end else begin
            if (sv_wr)
                wr_seen_q <= 1'b1;
            else if (!clk_en)
                wr_seen_q <= 1'b0;
            if (sv_wr)
                cyc_q <= 4'h0;
            else if (bus_cycle_end && cyc_q != 4'hf)
                cyc_q <= cyc_q + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_stop_after_write: assert property ($fell(clk_en) |-> wr_seen_q)
        else $error("clock stopped without a supervisor write");
    chk_stop_cycle_count: assert property ($fell(clk_en) |-> cyc_q >= (bus_8bit ? 3 : 2))
        else $error("clock stopped before the fetch cycles ended");
    chk_stable_wait: assert property ($fell(clk_en) |-> !restart [*8])
        else $error("restart raised too soon after clock stop");
    chk_restart_stopped: assert property ($rose(restart) |-> !clk_en)
        else $error("restart raised while clock running");
    chk_restart_enable: assert property ($rose(restart) |-> ##[1:3] clk_en)
        else $error("clock not resumed after restart");
    chk_enable_cause: assert property ($rose(clk_en) |-> $past(restart, 2))
        else $error("clock resumed without synchronised restart");
    chk_request_drop: assert property ($rose(clk_en) |-> ##[0:3] !bus_request_in)
        else $error("bus request kept after resume");
    chk_grant_request: assert property ($rose(bus_grant) |-> bus_request_in)
        else $error("grant without request");
    chk_width_static: assert property (!clk_en |-> $stable(bus_8bit))
        else $error("width select changed while halted");
endmodule

// ---- lowpower_clock_gate_seq_tb.sv ----
// testbench for both ends of the low-power clock gating link
`timescale 1ns/10ps
module lowpower_clock_gate_seq_tb;
    logic        clk = 0, reset_n = 0, sw_trap = 0, sw_write_lp = 0;
    logic        mode_8bit = 0, float_bus = 0;
    logic [23:0] lp_addr = 24'hc3a5e0;
    logic [2:0]  wake_level = 3'h5, irq_level = 3'h0;
    logic        addr_hit, clk_stopped, supervisor, asleep, bus_floated;
    int          failures = 0, samples_checked = 0, n16, n8;
    always #25 clk = ~clk;
    lpcg_link_if lnk ();
    lpcg_proc_end u_lpcg_proc_end (.clk(clk), .reset_n(reset_n), .lnk(lnk), .sw_trap(sw_trap),
        .sw_write_lp(sw_write_lp), .lp_addr(lp_addr), .wake_level(wake_level),
        .irq_level(irq_level), .mode_8bit(mode_8bit), .supervisor(supervisor),
        .asleep(asleep), .bus_floated(bus_floated));
    lpcg_gate_end u_lpcg_gate_end (.clk(clk), .reset_n(reset_n), .lnk(lnk), .lp_addr(lp_addr),
        .wake_level(wake_level), .mode_8bit(mode_8bit), .float_bus(float_bus),
        .addr_hit(addr_hit), .clk_stopped(clk_stopped));
    lpcg_asserts u_lpcg_asserts (.clk(clk), .reset_n(reset_n), .rw(lnk.rw),
        .function_code_outputs(lnk.function_code_outputs), .bus_cycle_end(lnk.bus_cycle_end),
        .clk_en(lnk.clk_en), .restart(lnk.restart), .bus_request_in(lnk.bus_request_in),
        .bus_grant(lnk.bus_grant), .bus_8bit(lnk.bus_8bit));
    task tick; @(posedge clk); #2; endtask
    task check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checked %0d, failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task sleep_wake(input logic m8, input logic flt, output int n);
        logic hit;
        int   i;
        mode_8bit = m8; float_bus = flt; hit = 0; n = 0;
        sw_write_lp = 1; tick; sw_write_lp = 0;
        repeat (20) tick;
        check(clk_stopped, 0);
        check(lnk.bus_8bit, m8);
        sw_trap = 1; tick; sw_trap = 0; tick; tick;
        check(supervisor, 1);
        sw_write_lp = 1; tick; sw_write_lp = 0;
        for (i = 0; i < 40 && clk_stopped !== 1'b1; i++) begin
            hit |= addr_hit; n++; tick;
        end
        check(hit, 1);
        check(clk_stopped, 1);
        check(bus_floated, flt);
        irq_level = 3'h3; repeat (40) tick;
        check(asleep, 1);
        irq_level = wake_level;
        for (i = 0; i < 100 && lnk.clk_en !== 1'b1; i++) tick;
        check(lnk.clk_en, 1);
        check(i >= 16, 1);
        repeat (4) tick;
        check(clk_stopped, 0);
        check(asleep, 0);
        check(lnk.bus_request_in, 0);
        irq_level = 3'h0; repeat (5) tick;
    endtask
    initial begin
        #(50 * 4000);
        failures++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge clk);
        #2 reset_n = 1; tick; tick;
        sleep_wake(0, 0, n16);
        $display("test 16-bit sleep and wake done");
        reset_n = 0; tick; reset_n = 1; tick; tick;
        sleep_wake(1, 1, n8);
        check(n8 > n16, 1);
        $display("test 8-bit floated sleep and wake done");
        conclude;
    end
endmodule
